// ---- design/lpwc_low_power_cfg.sv ----
/*
 * low-power configuration register bank of a switch detection
 * interface: comparator-only and sleep threshold selection per channel,
 * reached by 32-bit serial frames, plus the per-channel controls
 * those registers steer.
 * assumes: fault_status, int_flag, low_power_state and prog_is_battery
 * come from logic on ref_clk; comparator outputs are asynchronous.
 */
// Overview of operation
// - comparator-only channel keeps comparator on in low power, polling current off
// - comparator-only channel follows its digital input and wakes on change
// - register 0x12 holds comparator-only bits of eight prog inputs, reset 0
// - register 0x13 holds comparator-only bits of fourteen ground inputs, reset 0
// - ground switch with threshold bit clear uses reduced delta threshold
// - ground switch with threshold bit set uses the normal threshold
// - battery-configured prog input always uses normal threshold, ignoring its bit
// - register 0x14 holds sleep threshold bits of prog inputs, reset 0
// - register 0x15 holds sleep threshold bits of ground inputs, reset 0
// - frame is address 31..25, read/write bit 24, data 23..0
module lpwc_low_power_cfg (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // serial link
   input wire logic sclk,
   input wire logic cs_b,
   input wire logic mosi,
   output logic miso,
   // device status
   input wire logic fault_status,
   input wire logic int_flag,
   input wire logic low_power_state,
   input wire logic [7:0] prog_is_battery,
   // comparator results
   input wire logic [7:0] comp_prog_inputs,
   input wire logic [13:0] comp_ground_switch_inputs,
   // channel controls
   output logic [7:0] comp_active_prog_inputs,
   output logic [13:0] comp_active_ground_switch_inputs,
   output logic [7:0] poll_current_prog_inputs,
   output logic [13:0] poll_current_ground_switch_inputs,
   output logic [7:0] normal_input_threshold_prog_inputs,
   output logic [13:0] normal_input_threshold_ground_switch_inputs,
   output logic wake_request,
   // register contents
   output logic [7:0] comparator_only_prog_out,
   output logic [13:0] comparator_only_ground_out,
   output logic [7:0] sleep_threshold_prog_out,
   output logic [13:0] sleep_threshold_ground_out
);

   // ************************************************************
   // state
   // ************************************************************
   typedef struct packed {
      lpwc_pkg::lpwc_state_t state;
      logic [2:0] done_sync;
      logic [31:0] frame;
      logic [31:0] tx_word;
      logic [7:0] comparator_only_prog;
      logic [13:0] comparator_only_ground;
      logic [7:0] sleep_threshold_prog;
      logic [13:0] sleep_threshold_ground;
      logic [7:0] cp_s1;
      logic [7:0] cp_s2;
      logic [7:0] cp_prev;
      logic [13:0] cg_s1;
      logic [13:0] cg_s2;
      logic [13:0] cg_prev;
      logic [7:0] comp_act_p;
      logic [13:0] comp_act_g;
      logic [7:0] poll_p;
      logic [13:0] poll_g;
      logic [7:0] thr_p;
      logic [13:0] thr_g;
      logic wake;
   } lpwc_regs_t;

   lpwc_regs_t cur;
   lpwc_regs_t next_cur;
   logic [31:0] link_frame;
   logic link_done;

   // ************************************************************
   // link end
   // ************************************************************
   lpwc_link u_link (
      .sclk(sclk),
      .cs_b(cs_b),
      .mosi(mosi),
      .miso(miso),
      .tx_word(cur.tx_word),
      .frame_word(link_frame),
      .frame_done(link_done)
   );

   // ************************************************************
   // next state
   // ************************************************************
   always_comb begin
      logic [6:0] addr;
      logic wr;
      logic [23:0] wdata;
      logic [21:0] rdata;
      logic [7:0] ch_p;
      logic [13:0] ch_g;
      next_cur = cur;
      addr = cur.frame[lpwc_pkg::ADDR_MSB:lpwc_pkg::ADDR_LSB];
      wr = (cur.frame[lpwc_pkg::RW_BIT] == lpwc_pkg::RW_WRITE);
      wdata = cur.frame[23:0];
      rdata = '0;
      ch_p = '0;
      ch_g = '0;

      // done level crosses by two flops; the third only finds its edge
      next_cur.done_sync = {cur.done_sync[1:0], link_done};
      next_cur.cp_s1 = comp_prog_inputs;
      next_cur.cp_s2 = cur.cp_s1;
      next_cur.cp_prev = cur.cp_s2;
      next_cur.cg_s1 = comp_ground_switch_inputs;
      next_cur.cg_s2 = cur.cg_s1;
      next_cur.cg_prev = cur.cg_s2;

      case (cur.state)
         lpwc_pkg::ST_WAIT: begin
            // frame word stays put until the next frame's last bit
            if (cur.done_sync[1] && !cur.done_sync[2]) begin
               next_cur.frame = link_frame;
               next_cur.state = lpwc_pkg::ST_EXEC;
            end
         end
         lpwc_pkg::ST_EXEC: begin
            case (addr)
               lpwc_pkg::ADDR_COMP_ONLY_PROG: begin
                  if (wr) begin
                     next_cur.comparator_only_prog = wdata[7:0];
                  end
                  rdata = {14'h0000, next_cur.comparator_only_prog};
               end
               lpwc_pkg::ADDR_COMP_ONLY_GROUND: begin
                  if (wr) begin
                     next_cur.comparator_only_ground = wdata[13:0];
                  end
                  rdata = {8'h00, next_cur.comparator_only_ground};
               end
               lpwc_pkg::ADDR_SLEEP_THR_PROG: begin
                  if (wr) begin
                     next_cur.sleep_threshold_prog = wdata[7:0];
                  end
                  rdata = {14'h0000, next_cur.sleep_threshold_prog};
               end
               lpwc_pkg::ADDR_SLEEP_THR_GROUND: begin
                  if (wr) begin
                     next_cur.sleep_threshold_ground = wdata[13:0];
                  end
                  rdata = {8'h00, next_cur.sleep_threshold_ground};
               end
               default: begin
                  // other addresses belong to other banks; answer zero data
                  rdata = '0;
               end
            endcase
            next_cur.tx_word = {lpwc_pkg::RESP_HEAD, fault_status, int_flag, rdata};
            next_cur.state = lpwc_pkg::ST_WAIT;
         end
         default: begin
            next_cur.state = lpwc_pkg::ST_WAIT;
         end
      endcase

      // channel controls follow the stored bits and the power state
      if (low_power_state) begin
         next_cur.comp_act_p = cur.comparator_only_prog;
         next_cur.comp_act_g = cur.comparator_only_ground;
         next_cur.poll_p = ~cur.comparator_only_prog;
         next_cur.poll_g = ~cur.comparator_only_ground;
      end else begin
         next_cur.comp_act_p = '0;
         next_cur.comp_act_g = '0;
         next_cur.poll_p = '0;
         next_cur.poll_g = '0;
      end
      // battery inputs fix the normal threshold; host sets a current that can reach it
      next_cur.thr_p = cur.sleep_threshold_prog | prog_is_battery;
      next_cur.thr_g = cur.sleep_threshold_ground;

      // change of a comparator-only input in low power raises wake
      ch_p = (cur.cp_s2 ^ cur.cp_prev) & cur.comparator_only_prog;
      ch_g = (cur.cg_s2 ^ cur.cg_prev) & cur.comparator_only_ground;
      if (!low_power_state) begin
         next_cur.wake = 1'b0;
      end
      // a change in the cycle low power ends is dropped; the clear wins
      if (low_power_state && ((|ch_p) || (|ch_g))) begin
         next_cur.wake = 1'b1;
      end
   end

   // ************************************************************
   // registers
   // ************************************************************
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         cur <= '0;
         cur.state <= lpwc_pkg::ST_WAIT;
         cur.comparator_only_prog <= lpwc_pkg::RST_COMP_ONLY_PROG;
         cur.comparator_only_ground <= lpwc_pkg::RST_COMP_ONLY_GROUND;
         cur.sleep_threshold_prog <= lpwc_pkg::RST_SLEEP_THR_PROG;
         cur.sleep_threshold_ground <= lpwc_pkg::RST_SLEEP_THR_GROUND;
      end else begin
         cur <= next_cur;
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   assign comp_active_prog_inputs = cur.comp_act_p;
   assign comp_active_ground_switch_inputs = cur.comp_act_g;
   assign poll_current_prog_inputs = cur.poll_p;
   assign poll_current_ground_switch_inputs = cur.poll_g;
   assign normal_input_threshold_prog_inputs = cur.thr_p;
   assign normal_input_threshold_ground_switch_inputs = cur.thr_g;
   assign wake_request = cur.wake;
   assign comparator_only_prog_out = cur.comparator_only_prog;
   assign comparator_only_ground_out = cur.comparator_only_ground;
   assign sleep_threshold_prog_out = cur.sleep_threshold_prog;
   assign sleep_threshold_ground_out = cur.sleep_threshold_ground;

endmodule : lpwc_low_power_cfg

// ---- design/lpwc_pkg.sv ----
/*
 * constants, frame layout and state codes of the low-power wake input
 * configuration block.
 * assumes: shared by the register bank top and its serial link end.
 */
package lpwc_pkg;

   // ************************************************************
   // frame layout
   // ************************************************************
   localparam int FRAME_BITS = 32;
   localparam int ADDR_MSB = 31;
   localparam int ADDR_LSB = 25;
   localparam int RW_BIT = 24;
   localparam int FAULT_BIT = 23;
   localparam int INT_BIT = 22;
   localparam int REG_DATA_W = 22;
   localparam logic RW_WRITE = 1'h1;
   localparam logic [7:0] RESP_HEAD = 8'h00;
   localparam logic [5:0] BIT_CNT_LAST = 6'h1F;
   localparam logic [5:0] BIT_CNT_DONE = 6'h20;

   // ************************************************************
   // channels
   // ************************************************************
   localparam int PROG_CH = 8;
   localparam int GND_CH = 14;

   // ************************************************************
   // register addresses and reset values
   // ************************************************************
   localparam logic [6:0] ADDR_COMP_ONLY_PROG = 7'h12;
   localparam logic [6:0] ADDR_COMP_ONLY_GROUND = 7'h13;
   localparam logic [6:0] ADDR_SLEEP_THR_PROG = 7'h14;
   localparam logic [6:0] ADDR_SLEEP_THR_GROUND = 7'h15;
   localparam logic [7:0] RST_COMP_ONLY_PROG = 8'h00;
   localparam logic [13:0] RST_COMP_ONLY_GROUND = 14'h0000;
   localparam logic [7:0] RST_SLEEP_THR_PROG = 8'h00;
   localparam logic [13:0] RST_SLEEP_THR_GROUND = 14'h0000;

   // ************************************************************
   // frame handling states
   // ************************************************************
   typedef enum logic [1:0] {
      ST_WAIT = 2'h1,
      ST_EXEC = 2'h2
   } lpwc_state_t;

endpackage : lpwc_pkg

// ---- design/lpwc_link.sv ----
/*
 * serial link end: shifts one 32-bit frame in on the link clock and
 * shifts the prepared answer word out.
 * assumes: mode 0 (sample on rising, change on falling), msb first,
 * chip select low for the whole frame; the link clock stands still
 * outside frames, so chip select high clears the frame logic.
 */
module lpwc_link (
   // link pins
   input wire logic sclk,
   input wire logic cs_b,
   input wire logic mosi,
   output logic miso,
   // towards the register bank
   input wire logic [31:0] tx_word,
   output logic [31:0] frame_word,
   output logic frame_done
);

   // ************************************************************
   // state
   // ************************************************************
   typedef struct packed {
      logic [5:0] bit_cnt;
      logic [31:0] rx_sh;
      logic [31:0] tx_hold;
      logic done;
   } lpwc_link_t;

   lpwc_link_t cur;
   lpwc_link_t next_cur;
   logic [31:0] frame_q;
   logic [31:0] next_frame_q;
   logic [4:0] out_idx;

   // ************************************************************
   // receive
   // ************************************************************
   always_comb begin
      next_cur = cur;
      next_frame_q = frame_q;
      if (cur.bit_cnt == 6'h00) begin
         next_cur.tx_hold = tx_word;
      end
      if (cur.bit_cnt != lpwc_pkg::BIT_CNT_DONE) begin
         next_cur.rx_sh = {cur.rx_sh[30:0], mosi};
         next_cur.bit_cnt = 6'(cur.bit_cnt + 6'h01);
      end
      // extra clocks past bit 32 are ignored
      if (cur.bit_cnt == lpwc_pkg::BIT_CNT_LAST) begin
         next_frame_q = {cur.rx_sh[30:0], mosi};
         next_cur.done = 1'b1;
      end
   end

   always_ff @(posedge sclk or posedge cs_b) begin
      if (cs_b) begin
         cur <= '0;
      end else begin
         cur <= next_cur;
      end
   end

   // frame word is left unreset so it outlives chip select
   always_ff @(posedge sclk) begin
      frame_q <= next_frame_q;
   end

   // ************************************************************
   // transmit
   // ************************************************************
   assign out_idx = 5'(6'h1F - cur.bit_cnt);

   // bit 31 is the constant head bit, so the reset value serves it
   always_ff @(negedge sclk or posedge cs_b) begin
      if (cs_b) begin
         miso <= 1'b0;
      end else if (cur.bit_cnt < lpwc_pkg::BIT_CNT_DONE) begin
         miso <= cur.tx_hold[out_idx];
      end else begin
         miso <= 1'b0;
      end
   end

   assign frame_word = frame_q;
   assign frame_done = cur.done;

endmodule : lpwc_link

// ---- verification/lpwc_cfg_chk.sv ----
/*
 * checker of the channel controls of the low-power configuration bank.
 * assumes: bound to lpwc_low_power_cfg and sees only its ports.
 */
module lpwc_cfg_chk (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // device status
   input wire logic low_power_state,
   input wire logic [7:0] prog_is_battery,
   // channel controls
   input wire logic [7:0] comp_active_prog_inputs,
   input wire logic [13:0] comp_active_ground_switch_inputs,
   input wire logic [7:0] poll_current_prog_inputs,
   input wire logic [13:0] poll_current_ground_switch_inputs,
   input wire logic [7:0] normal_input_threshold_prog_inputs,
   input wire logic [13:0] normal_input_threshold_ground_switch_inputs,
   input wire logic wake_request,
   // register contents
   input wire logic [7:0] comparator_only_prog_out,
   input wire logic [13:0] comparator_only_ground_out,
   input wire logic [7:0] sleep_threshold_prog_out,
   input wire logic [13:0] sleep_threshold_ground_out
);
   timeunit 1ns;
   timeprecision 100ps;
   // ************************************************************
   // properties
   // ************************************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   // judged only on steady causes, so the lag of the register copy does not matter
   sequence s_awake;
      !low_power_state [*3];
   endsequence
   sequence s_woken;
      !wake_request ##1 wake_request;
   endsequence
   a_comp_on_prog: assert property ($stable(comparator_only_prog_out) && $stable(low_power_state)
      |-> comp_active_prog_inputs == (low_power_state ? comparator_only_prog_out : 8'h00))
      else $error("prog comparator enable wrong");
   a_comp_on_gnd: assert property ($stable(comparator_only_ground_out) && $stable(low_power_state)
      |-> comp_active_ground_switch_inputs == (low_power_state ? comparator_only_ground_out
      : 14'h0000)) else $error("ground comparator enable wrong");
   a_poll_off_prog: assert property ($stable(comparator_only_prog_out) && $stable(low_power_state)
      |-> poll_current_prog_inputs == (low_power_state ? ~comparator_only_prog_out : 8'h00))
      else $error("prog polling current wrong");
   a_poll_off_gnd: assert property ($stable(comparator_only_ground_out) && $stable(low_power_state)
      |-> poll_current_ground_switch_inputs == (low_power_state ? ~comparator_only_ground_out
      : 14'h0000)) else $error("ground polling current wrong");
   a_thr_sel_prog: assert property ($stable(sleep_threshold_prog_out) && $stable(prog_is_battery)
      |-> normal_input_threshold_prog_inputs == (sleep_threshold_prog_out | prog_is_battery))
      else $error("prog threshold choice wrong");
   a_thr_sel_gnd: assert property ($stable(sleep_threshold_ground_out)
      |-> normal_input_threshold_ground_switch_inputs == sleep_threshold_ground_out)
      else $error("ground threshold choice wrong");
   a_wake_in_lp: assert property (s_woken |-> $past(low_power_state))
      else $error("wake raised outside low power");
   a_wake_holds: assert property (wake_request && low_power_state |=> wake_request)
      else $error("wake dropped during low power");
   a_wake_clears: assert property (s_awake |=> !wake_request)
      else $error("wake kept after low power ended");
endmodule : lpwc_cfg_chk

bind lpwc_low_power_cfg lpwc_cfg_chk u_chk (.ref_clk(ref_clk), .rst(rst),
   .low_power_state(low_power_state), .prog_is_battery(prog_is_battery),
   .comp_active_prog_inputs(comp_active_prog_inputs),
   .comp_active_ground_switch_inputs(comp_active_ground_switch_inputs),
   .poll_current_prog_inputs(poll_current_prog_inputs),
   .poll_current_ground_switch_inputs(poll_current_ground_switch_inputs),
   .normal_input_threshold_prog_inputs(normal_input_threshold_prog_inputs),
   .normal_input_threshold_ground_switch_inputs(normal_input_threshold_ground_switch_inputs),
   .wake_request(wake_request), .comparator_only_prog_out(comparator_only_prog_out),
   .comparator_only_ground_out(comparator_only_ground_out),
   .sleep_threshold_prog_out(sleep_threshold_prog_out),
   .sleep_threshold_ground_out(sleep_threshold_ground_out));

// ---- verification/lpwc_host_model.sv ----
/*
 * host model: serial link master sending one 32-bit frame per call.
 * assumes: the device samples on rising link clock, changes miso on falling.
 */
module lpwc_host_model (
   // link pins
   output logic sclk,
   output logic cs_b,
   output logic mosi,
   input wire logic miso
);
   timeunit 1ns;
   timeprecision 100ps;
   // a clean rising chip select at start clears the link frame logic
   initial begin
      sclk = 1'b0;
      cs_b = 1'b0;
      mosi = 1'b0;
      #1 cs_b = 1'b1;
   end
   // ************************************************************
   // frame
   // ************************************************************
   // frames carry comparator-only and threshold choices; current levels are set elsewhere
   task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
      cs_b = 1'b0;
      #40;
      for (int i = 31; i >= 0; i--) begin
         mosi = tx[i];
         #7.5 sclk = 1'b1;
         rx[i] = miso;
         #7.5 sclk = 1'b0;
      end
      #40 cs_b = 1'b1;
      // clock stays still; data line shows the inverse so a stale bit cannot pass
      mosi = ~mosi;
      #100;
   endtask : xfer
endmodule : lpwc_host_model

// ---- verification/test_lpwc_low_power_cfg.sv ----
/*
 * testbench of the low-power configuration bank: frames through the host
 * model, then channel controls and wake on the ref_clk side.
 * assumes: lpwc_host_model and the bound checker are compiled alongside.
 */
module test_lpwc_low_power_cfg;
   timeunit 1ns;
   timeprecision 100ps;
   logic ref_clk, rst, sclk, cs_b, mosi, miso, fault_status, int_flag, low_power_state;
   logic wake_request;
   logic [7:0] prog_is_battery, comp_p, ca_p, pc_p, nt_p, co_p, st_p;
   logic [13:0] comp_g, ca_g, pc_g, nt_g, co_g, st_g;
   logic [31:0] rx;
   logic [6:0] addrs [4] = '{7'h12, 7'h13, 7'h14, 7'h15};
   logic [21:0] masks [4] = '{22'hFF, 22'h3FFF, 22'hFF, 22'h3FFF};
   int err_count = 0;
   int tests_run = 0;
   lpwc_low_power_cfg uut (.ref_clk(ref_clk), .rst(rst), .sclk(sclk), .cs_b(cs_b),
      .mosi(mosi), .miso(miso), .fault_status(fault_status), .int_flag(int_flag),
      .low_power_state(low_power_state), .prog_is_battery(prog_is_battery),
      .comp_prog_inputs(comp_p), .comp_ground_switch_inputs(comp_g),
      .comp_active_prog_inputs(ca_p), .comp_active_ground_switch_inputs(ca_g),
      .poll_current_prog_inputs(pc_p), .poll_current_ground_switch_inputs(pc_g),
      .normal_input_threshold_prog_inputs(nt_p),
      .normal_input_threshold_ground_switch_inputs(nt_g), .wake_request(wake_request),
      .comparator_only_prog_out(co_p), .comparator_only_ground_out(co_g),
      .sleep_threshold_prog_out(st_p), .sleep_threshold_ground_out(st_g));
   lpwc_host_model host (.sclk(sclk), .cs_b(cs_b), .mosi(mosi), .miso(miso));
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   // ************************************************************
   // tasks
   // ************************************************************
   // wide enough for the 44-bit register and control snapshots
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_count++;
         $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   // answer comes one frame late, so a second frame fetches it
   task automatic acc(input logic [6:0] a, input logic wr, input logic [23:0] d,
      input logic [21:0] exp);
      host.xfer({a, wr, d}, rx);
      host.xfer(32'h00000000, rx);
      chk(rx, {8'h00, fault_status, int_flag, exp});
   endtask : acc
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : cyc
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : tally_and_finish
   initial begin
      #300000;
      err_count++;
      tally_and_finish();
   end
   // ************************************************************
   // tests
   // ************************************************************
   initial begin
      rst = 1'b1;
      {fault_status, int_flag, low_power_state, prog_is_battery, comp_p, comp_g} = '0;
      cyc(12);
      rst = 1'b0;
      cyc(10);
      for (int i = 0; i < 4; i++) acc(addrs[i], 1'b0, 24'h000000, 22'h0);
      $display("test reset values done");
      fault_status = 1'b1;
      for (int i = 0; i < 4; i++) acc(addrs[i], 1'b1, 24'hFFFFFF, masks[i]);
      cyc(1);
      fault_status = 1'b0;
      int_flag = 1'b1;
      acc(7'h16, 1'b1, 24'h00ABCD, 22'h0);
      chk({co_g, co_p, st_g, st_p}, 44'hFFFFFFFFFFF);
      $display("test masks and status bits done");
      acc(7'h12, 1'b1, 24'hFFFF01, 22'h01);
      acc(7'h13, 1'b1, 24'h000002, 22'h0002);
      acc(7'h14, 1'b1, 24'h00000F, 22'h0F);
      acc(7'h15, 1'b1, 24'h0000F0, 22'h00F0);
      acc(7'h12, 1'b0, 24'h0000FE, 22'h01);
      prog_is_battery = 8'h30;
      cyc(3);
      chk({nt_g, nt_p}, 22'h00F03F);
      chk({ca_g, ca_p, pc_g, pc_p}, 44'h0);
      low_power_state = 1'b1;
      cyc(3);
      chk({ca_g, ca_p, pc_g, pc_p}, 44'h000807FFDFE);
      comp_p = 8'h02;
      cyc(8);
      chk(32'(wake_request), 32'h0);
      comp_p = 8'h03;
      cyc(8);
      chk(32'(wake_request), 32'h1);
      low_power_state = 1'b0;
      cyc(4);
      chk({wake_request, ca_p, pc_p}, 17'h0);
      low_power_state = 1'b1;
      cyc(3);
      comp_g = 14'h0002;
      cyc(8);
      chk(32'(wake_request), 32'h1);
      low_power_state = 1'b0;
      cyc(4);
      $display("test channel controls done");
      tally_and_finish();
   end
endmodule : test_lpwc_low_power_cfg
